// File: rtl/acr_pkg.sv
package acr_pkg;

   // Bus geometry of the register slave.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = ADDR_W - 2;
   localparam int STRB_W = DATA_W / 8;
   localparam int REG_W = 8;
   localparam int NUM_REGS = 4;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_CONV_CONFIG = 10'h015;
   localparam logic [IDX_W-1:0] IDX_INPUT_SELECT = 10'h016;
   localparam logic [IDX_W-1:0] IDX_OFFSET_LOW = 10'h017;
   localparam logic [IDX_W-1:0] IDX_OFFSET_HIGH = 10'h018;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // Reset values of the four byte registers.
   localparam logic [REG_W-1:0] RST_CONV_CONFIG = 8'h00;
   localparam logic [REG_W-1:0] RST_INPUT_SELECT = 8'h01;
   localparam logic [REG_W-1:0] RST_OFFSET = 8'h00;

   // Output rate codes and the rate each one gives, in samples per second.
   typedef enum logic [1:0] {
      RATE_10 = 2'b00,
      RATE_100 = 2'b01,
      RATE_400 = 2'b10,
      RATE_800 = 2'b11
   } acr_rate_t;
   localparam logic [9:0] SPS_10 = 10'h00a;
   localparam logic [9:0] SPS_100 = 10'h064;
   localparam logic [9:0] SPS_400 = 10'h190;
   localparam logic [9:0] SPS_800 = 10'h320;

   // Reference pair codes.
   typedef enum logic [2:0] {
      REF_INTERNAL = 3'b000,
      REF_EXT_01 = 3'b001,
      REF_EXT_23 = 3'b010,
      REF_EXT_45 = 3'b011,
      REF_SUPPLY = 3'b100,
      REF_RSV5 = 3'b101,
      REF_RSV6 = 3'b110,
      REF_RSV7 = 3'b111
   } acr_ref_t;

   // Gain is one shifted left by the gain code.
   localparam logic [7:0] GAIN_UNITY = 8'h01;

   // Configuration byte layout, most significant field first.
   typedef struct packed {
      acr_rate_t rate;
      acr_ref_t ref_sel;
      logic [2:0] gain;
   } acr_conv_cfg_t;

   // Multiplexer channel codes, shared by both selectors.
   typedef enum logic [3:0] {
      CH_AIN0 = 4'h0, CH_AIN1 = 4'h1, CH_AIN2 = 4'h2, CH_AIN3 = 4'h3,
      CH_AIN4 = 4'h4, CH_AIN5 = 4'h5, CH_AIN6 = 4'h6, CH_AIN7 = 4'h7,
      CH_AIN8 = 4'h8, CH_AIN9 = 4'h9, CH_COMMON = 4'ha, CH_TEMP = 4'hb,
      CH_AVDD_MON = 4'hc, CH_DVDD_MON = 4'hd, CH_TEST_DAC = 4'he,
      CH_OPEN = 4'hf
   } acr_chan_t;

   // Input select byte layout.
   typedef struct packed {
      acr_chan_t pos;
      acr_chan_t neg;
   } acr_mux_t;

   // One-hot routing of one converter input side.
   localparam int PIN_N = 11;
   localparam int MON_N = 4;
   localparam logic [PIN_N-1:0] PIN_ONE = 11'h001;
   localparam logic [MON_N-1:0] MON_ONE = 4'h1;
   typedef struct packed {
      logic [PIN_N-1:0] pin_sel;
      logic [MON_N-1:0] mon_sel;
      logic mon_neg;
      logic open;
   } acr_route_t;

   // Offset correction geometry.
   localparam int RESULT_W = 24;
   localparam int OFFSET_W = 16;
   localparam int OFFSET_SHIFT = RESULT_W - OFFSET_W;
   typedef struct packed {
      logic valid;
      logic [RESULT_W-1:0] data;
   } acr_sample_t;

endpackage

// File: rtl/acr_reg8.sv
`timescale 1ns/1ps
module acr_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] q
);

   // Byte register that loads on a qualified bus write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET_VALUE;
      end else if (wr_en) begin
         q <= wr_data;
      end
   end

endmodule

// File: rtl/acr_offset_sub.sv
`timescale 1ns/1ps
module acr_offset_sub (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [acr_pkg::OFFSET_W-1:0] offset_word,
   input acr_pkg::acr_sample_t raw,
   output acr_pkg::acr_sample_t corr,
   output logic overflow
);
   import acr_pkg::*;

   logic signed [RESULT_W:0] raw_ext;
   logic signed [RESULT_W:0] off_ext;
   logic signed [RESULT_W:0] diff;
   logic sat;
   logic [RESULT_W-1:0] next_data;

   // Sign-extend both terms, align the offset and take the difference.
   assign raw_ext = $signed({raw.data[RESULT_W-1], raw.data});
   assign off_ext = $signed({offset_word[OFFSET_W-1], offset_word,
                             {OFFSET_SHIFT{1'b0}}});
   assign diff = raw_ext - off_ext;
   assign sat = diff[RESULT_W] != diff[RESULT_W-1];
   // Clamp rather than wrap, so an overflow cannot flip the sign.
   assign next_data = !sat ? diff[RESULT_W-1:0] :
      {diff[RESULT_W], {(RESULT_W-1){~diff[RESULT_W]}}};

   // Register the corrected sample one cycle after the raw one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corr <= '0;
         overflow <= 1'b0;
      end else begin
         corr.valid <= raw.valid;
         if (raw.valid) begin
            corr.data <= next_data;
            overflow <= sat;
         end
      end
   end

endmodule

// File: rtl/acr_top.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps

// Function
// RL1: Rate bits 7:6 select 10, 100, 400 or 800 samples per second.
// RL2: Reference bits 5:3 pick internal, pin pairs or supply; 5-7 reserved.
// RL3: Gain bits 2:0 give a gain of two to the power of the code, 1 to 128.
// RL4: The configuration register is index 15h, resets to 00h and is R/W.
// RL5: Positive bits 7:4 pick inputs 0-9, common, monitors, test or open.
// RL6: Negative bits 3:0 map alike but take the negative monitor sides.
// RL7: The input select register is index 16h and resets to 01h.
// RL8: The offset word is index 18h over index 17h, both reset to 00h.
// RL9: The signed offset, shifted up to 24 bits, is taken from each result.
// RL10: Reads return the last write or reset value, with no side effect.
module acr_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [acr_pkg::ADDR_W-1:0] paddr,
   input wire logic [acr_pkg::DATA_W-1:0] pwdata,
   input wire logic [acr_pkg::STRB_W-1:0] pstrb,
   output logic [acr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output acr_pkg::acr_conv_cfg_t conv_cfg,
   output logic [9:0] rate_sps,
   output acr_pkg::acr_ref_t ref_sel,
   output logic ref_reserved,
   output logic [7:0] gain_factor,
   output acr_pkg::acr_mux_t input_sel,
   output acr_pkg::acr_route_t pos_route,
   output acr_pkg::acr_route_t neg_route,
   output logic [acr_pkg::OFFSET_W-1:0] offset_word,
   input acr_pkg::acr_sample_t raw_sample,
   output acr_pkg::acr_sample_t corr_sample,
   output logic corr_overflow
);
   import acr_pkg::*;

   logic setup_phase;
   logic access_phase;
   logic [IDX_W-1:0] reg_idx;
   logic aligned;
   logic [NUM_REGS-1:0] reg_hit;
   logic any_hit;
   logic wr_ok;
   logic [NUM_REGS-1:0] reg_wr;
   logic [REG_W-1:0] wr_byte;
   logic [REG_W-1:0] cfg_byte;
   logic [REG_W-1:0] mux_byte;
   logic [REG_W-1:0] off_low;
   logic [REG_W-1:0] off_high;
   logic [REG_W-1:0] rd_byte;
   logic [DATA_W-1:0] next_prdata;

   // Bus phase decode; the slave never inserts wait states.
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready = 1'b1;

   // Address decode: word aligned and one of the four indices.
   assign reg_idx = paddr[ADDR_W-1:2];
   assign aligned = paddr[1:0] == WORD_ALIGN;
   assign reg_hit[0] = aligned & (reg_idx == IDX_CONV_CONFIG);
   assign reg_hit[1] = aligned & (reg_idx == IDX_INPUT_SELECT);
   assign reg_hit[2] = aligned & (reg_idx == IDX_OFFSET_LOW);
   assign reg_hit[3] = aligned & (reg_idx == IDX_OFFSET_HIGH);
   assign any_hit = |reg_hit;

   // Unmapped addresses answer with an error and change nothing.
   assign pslverr = access_phase & ~any_hit;

   // A write lands only with lane 0 enabled, in the access phase.
   assign wr_ok = access_phase & pwrite & pstrb[0];
   assign reg_wr = reg_hit & {NUM_REGS{wr_ok}};
   assign wr_byte = pwdata[REG_W-1:0];

   // Converter configuration byte.
   acr_reg8 #(
      .RESET_VALUE(RST_CONV_CONFIG)
   ) u_conv_config (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(reg_wr[0]), // RL4
      .wr_data(wr_byte),
      .q(cfg_byte)
   );

   // Input select byte.
   acr_reg8 #(
      .RESET_VALUE(RST_INPUT_SELECT)
   ) u_input_select (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(reg_wr[1]), // RL7
      .wr_data(wr_byte),
      .q(mux_byte)
   );

   // Low byte of the offset word.
   acr_reg8 #(
      .RESET_VALUE(RST_OFFSET)
   ) u_offset_low (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(reg_wr[2]), // RL8
      .wr_data(wr_byte),
      .q(off_low)
   );

   // High byte of the offset word.
   acr_reg8 #(
      .RESET_VALUE(RST_OFFSET)
   ) u_offset_high (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(reg_wr[3]), // RL8
      .wr_data(wr_byte),
      .q(off_high)
   );

   // Read selection; upper bits and unmapped reads return zero.
   assign rd_byte = reg_hit[0] ? cfg_byte :
                    reg_hit[1] ? mux_byte :
                    reg_hit[2] ? off_low :
                    reg_hit[3] ? off_high : RST_OFFSET;
   assign next_prdata = {{(DATA_W-REG_W){1'b0}}, rd_byte};

   // Read data is captured in the setup cycle and held for the access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup_phase) begin
         prdata <= next_prdata; // RL10
      end
   end

   // Field views of the stored bytes.
   assign conv_cfg = acr_conv_cfg_t'(cfg_byte);
   assign input_sel = acr_mux_t'(mux_byte);
   assign ref_sel = conv_cfg.ref_sel;
   assign offset_word = {off_high, off_low}; // RL8

   // Output rate in samples per second.
   always_comb begin
      rate_sps = SPS_10;
      unique case (conv_cfg.rate)
         RATE_10: rate_sps = SPS_10; // RL1
         RATE_100: rate_sps = SPS_100;
         RATE_400: rate_sps = SPS_400;
         RATE_800: rate_sps = SPS_800;
      endcase
   end

   // Reserved reference codes are stored but flagged to the front end.
   assign ref_reserved = ref_sel >= REF_RSV5; // RL2

   // Gain doubles with each code step.
   assign gain_factor = GAIN_UNITY << conv_cfg.gain; // RL3

   // Routing of one selector code onto pins, monitors or open.
   function automatic acr_route_t route_of(input acr_chan_t ch,
                                           input logic neg_side);
      acr_route_t r;
      r = '0;
      if (ch <= CH_COMMON) begin
         r.pin_sel = PIN_ONE << ch;
      end else if (ch == CH_OPEN) begin
         r.open = 1'b1;
      end else begin
         r.mon_sel = MON_ONE << 4'(ch - CH_TEMP);
         r.mon_neg = neg_side;
      end
      return r;
   endfunction

   // Both selectors share the map; only the monitor side differs.
   assign pos_route = route_of(input_sel.pos, 1'b0); // RL5
   assign neg_route = route_of(input_sel.neg, 1'b1); // RL6

   // Offset correction of each raw sample.
   acr_offset_sub u_offset_sub (
      .pclk(pclk),
      .presetn(presetn),
      .offset_word(offset_word), // RL9
      .raw(raw_sample),
      .corr(corr_sample),
      .overflow(corr_overflow)
   );

   // Checks on decode, reset values, bus access and correction.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [RESULT_W:0] exp_diff;
   assign exp_diff = {raw_sample.data[RESULT_W-1], raw_sample.data} -
      {offset_word[OFFSET_W-1], offset_word, {OFFSET_SHIFT{1'b0}}};

   // The exact difference overflows when its two top bits differ.
   logic exp_sat;
   assign exp_sat = exp_diff[RESULT_W] != exp_diff[RESULT_W-1];

   chk_rate_code: assert property ( // RL1
      (conv_cfg.rate == RATE_800 |-> rate_sps == SPS_800) and
      (conv_cfg.rate == RATE_10 |-> rate_sps == SPS_10) and
      (conv_cfg.rate == RATE_400 |-> rate_sps == SPS_400))
      else $error("rate decode mismatch");

   chk_ref_reserved: assert property ( // RL2
      ref_reserved |-> (ref_sel != REF_SUPPLY && ref_sel != REF_INTERNAL))
      else $error("reference reserved flag wrong");

   chk_gain_power: assert property ( // RL3
      $onehot(gain_factor) && gain_factor[conv_cfg.gain])
      else $error("gain factor not a power of two of the code");

   chk_config_reset: assert property ( // RL4
      $rose(presetn) |-> cfg_byte == RST_CONV_CONFIG)
      else $error("configuration not at reset value");

   chk_pos_pin: assert property ( // RL5
      input_sel.pos <= CH_COMMON |->
         pos_route.pin_sel[input_sel.pos] && pos_route.mon_sel == '0 &&
         !pos_route.open && $onehot(pos_route.pin_sel))
      else $error("positive selector routing wrong");

   chk_neg_monitor: assert property ( // RL6
      (neg_route.mon_sel != '0) |-> neg_route.mon_neg &&
         input_sel.neg >= CH_TEMP && input_sel.neg <= CH_TEST_DAC)
      else $error("negative monitor side wrong");

   chk_mux_reset: assert property ( // RL7
      $rose(presetn) |-> input_sel.pos == CH_AIN0 &&
         input_sel.neg == CH_AIN1)
      else $error("input select not at reset value");

   chk_offset_join: assert property ( // RL8
      reg_wr[3] |=> offset_word[OFFSET_W-1:REG_W] == $past(wr_byte) &&
         offset_word[REG_W-1:0] == $past(off_low))
      else $error("high offset byte write wrong");

   chk_offset_apply: assert property ( // RL9
      raw_sample.valid && exp_diff[RESULT_W] == exp_diff[RESULT_W-1] |=>
         corr_sample.valid && !corr_overflow &&
         corr_sample.data == $past(exp_diff[RESULT_W-1:0]))
      else $error("offset correction result wrong");

   chk_write_readback: assert property ( // RL10
      reg_wr[0] ##2 (setup_phase && !pwrite && reg_hit[0]) |=>
         prdata == {{(DATA_W-REG_W){1'b0}}, $past(wr_byte, 3)})
      else $error("read back differs from last write");

   chk_unmapped_quiet: assert property ( // RL10
      pslverr |=> $stable(cfg_byte) && $stable(mux_byte) &&
         $stable(offset_word))
      else $error("unmapped access changed a register");

   // Decode checks for the configuration fields.
   chk_rate_mid: assert property ( // RL1
      conv_cfg.rate == RATE_100 |-> rate_sps == SPS_100)
      else $error("rate decode of the second code wrong");

   chk_ref_flag: assert property ( // RL2
      ref_reserved == (ref_sel inside {REF_RSV5, REF_RSV6, REF_RSV7}))
      else $error("reserved reference codes not flagged");

   chk_gain_unity: assert property ( // RL3
      conv_cfg.gain == '0 |-> gain_factor == GAIN_UNITY)
      else $error("lowest gain code is not unity");

   // Register bank checks: a write lands, and nothing else moves.
   chk_config_write: assert property ( // RL4
      reg_wr[0] |=> cfg_byte == $past(wr_byte))
      else $error("configuration write did not land");

   chk_config_hold: assert property ( // RL10
      !reg_wr[0] |=> $stable(cfg_byte))
      else $error("configuration changed without a write");

   chk_mux_write: assert property ( // RL7
      reg_wr[1] |=> mux_byte == $past(wr_byte))
      else $error("input select write did not land");

   chk_mux_hold: assert property ( // RL10
      !reg_wr[1] |=> $stable(mux_byte))
      else $error("input select changed without a write");

   chk_offset_low: assert property ( // RL8
      reg_wr[2] |=> off_low == $past(wr_byte) &&
         off_high == $past(off_high))
      else $error("low offset byte write wrong");

   chk_offset_hold: assert property ( // RL10
      !(reg_wr[2] || reg_wr[3]) |=> $stable(offset_word))
      else $error("offset word changed without a write");

   // Routing checks for both selectors.
   chk_pos_monitor: assert property ( // RL5
      (pos_route.mon_sel != '0) |-> !pos_route.mon_neg &&
         input_sel.pos >= CH_TEMP && input_sel.pos <= CH_TEST_DAC)
      else $error("positive monitor side wrong");

   chk_pos_open: assert property ( // RL5
      input_sel.pos == CH_OPEN |-> pos_route.open &&
         pos_route.pin_sel == '0 && pos_route.mon_sel == '0)
      else $error("open positive selector still routed");

   chk_neg_pin: assert property ( // RL6
      input_sel.neg <= CH_COMMON |->
         neg_route.pin_sel[input_sel.neg] && neg_route.mon_sel == '0 &&
         !neg_route.open && $onehot(neg_route.pin_sel))
      else $error("negative selector routing wrong");

   chk_neg_open: assert property ( // RL6
      input_sel.neg == CH_OPEN |-> neg_route.open &&
         neg_route.pin_sel == '0 && neg_route.mon_sel == '0)
      else $error("open negative selector still routed");

   // Correction path checks.
   chk_offset_clamp: assert property ( // RL9
      raw_sample.valid && exp_sat |=> corr_sample.valid && corr_overflow &&
         corr_sample.data[RESULT_W-1] == $past(exp_diff[RESULT_W]))
      else $error("saturated correction wrong");

   chk_corr_idle: assert property ( // RL9
      !raw_sample.valid |=> !corr_sample.valid)
      else $error("corrected sample without a raw one");

   // Bus answer checks.
   chk_zero_wait: assert property ( // RL10
      access_phase |-> pready)
      else $error("access phase not answered at once");

   chk_slverr_phase: assert property ( // RL10
      pslverr |-> access_phase && !any_hit)
      else $error("error response outside an unmapped access");

   chk_unmapped_zero: assert property ( // RL10
      setup_phase && !any_hit |=> prdata == '0)
      else $error("unmapped read returned data");

   cov_cfg_write: cover property (reg_wr[0] ##1 conv_cfg.rate == RATE_800);
   cov_mux_read: cover property (access_phase && !pwrite && reg_hit[1]);
   cov_unmapped: cover property (pslverr);
   cov_sample: cover property (raw_sample.valid ##1 corr_overflow);
   cov_neg_monitor: cover property (neg_route.mon_neg);

endmodule

// File: bench/acr_top_bench.sv
`timescale 1ns/1ps

// Compares a seen value with an expected one and counts the outcome.
`define CHK(nm, ex, got) begin \
   checked++; \
   if ((got) !== (ex)) begin \
      errors++; \
      $display("[ERR] %s expected %h seen %h", nm, (ex), (got)); \
   end \
end

module acr_top_bench;
   import acr_pkg::*;

   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [STRB_W-1:0] pstrb;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   acr_conv_cfg_t conv_cfg;
   logic [9:0] rate_sps;
   acr_ref_t ref_sel;
   logic ref_reserved;
   logic [7:0] gain_factor;
   acr_mux_t input_sel;
   acr_route_t pos_route;
   acr_route_t neg_route;
   logic [OFFSET_W-1:0] offset_word;
   acr_sample_t raw_sample;
   acr_sample_t corr_sample;
   logic corr_overflow;
   int errors;
   int checked;
   logic [31:0] seed;
   logic [7:0] mdl [4];
   logic [31:0] rd;
   logic err;

   acr_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_cfg(conv_cfg), .rate_sps(rate_sps), .ref_sel(ref_sel),
      .ref_reserved(ref_reserved), .gain_factor(gain_factor),
      .input_sel(input_sel), .pos_route(pos_route),
      .neg_route(neg_route), .offset_word(offset_word),
      .raw_sample(raw_sample), .corr_sample(corr_sample),
      .corr_overflow(corr_overflow)
   );

   // The clock runs at 10 MHz.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Xorshift source; the stream is the same on every run.
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Byte address of model slot i, counted from the configuration byte.
   function logic [ADDR_W-1:0] adr(int i);
      return {IDX_CONV_CONFIG + IDX_W'(i), WORD_ALIGN};
   endfunction

   // Samples per second for each rate code.
   function logic [9:0] sps(logic [1:0] c);
      case (c)
         2'b00: return 10'd10;
         2'b01: return 10'd100;
         2'b10: return 10'd400;
         default: return 10'd800;
      endcase
   endfunction

   // Expected one-hot routing of one selector code.
   function acr_route_t route(logic [3:0] c, logic n);
      acr_route_t r;
      r = '0;
      if (c < 4'hb) begin
         r.pin_sel = PIN_ONE << c;
      end else if (c < 4'hf) begin
         r.mon_sel = MON_ONE << (c - 4'hb);
         r.mon_neg = n;
      end else begin
         r.open = 1'b1;
      end
      return r;
   endfunction

   // One APB transfer; the request is held until pready is seen high.
   task apb(logic w, logic [ADDR_W-1:0] a, logic [7:0] d, logic [3:0] s);
      logic [31:0] r;
      r = rnd();
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {r[31:8], d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      `CHK("pready", 1'b1, pready)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Writes a register slot and updates the model.
   task wr(int i, logic [7:0] d);
      apb(1'b1, adr(i), d, 4'hf);
      mdl[i] = d;
      #1;
   endtask

   // Reads a register slot and compares it with the model.
   task rdchk(int i);
      apb(1'b0, adr(i), 8'h00, 4'h0);
      `CHK("prdata", {24'h0, mdl[i]}, rd)
      `CHK("pslverr", 1'b0, err)
   endtask

   // Compares every decoded output with the model.
   task chk_outs;
      `CHK("conv_cfg", mdl[0], conv_cfg)
      `CHK("rate_sps", sps(mdl[0][7:6]), rate_sps)
      `CHK("ref_sel", mdl[0][5:3], ref_sel)
      `CHK("ref_rsv", mdl[0][5:3] > 3'd4, ref_reserved)
      `CHK("gain", 8'h01 << mdl[0][2:0], gain_factor)
      `CHK("input_sel", mdl[1], input_sel)
      `CHK("pos_route", route(mdl[1][7:4], 1'b0), pos_route)
      `CHK("neg_route", route(mdl[1][3:0], 1'b1), neg_route)
      `CHK("offset", {mdl[3], mdl[2]}, offset_word)
   endtask

   // After a reset every register must read its reset value.
   task rst_chk;
      mdl = '{8'h00, 8'h01, 8'h00, 8'h00};
      `CHK("rst_cfg", 8'h00, conv_cfg)
      `CHK("rst_mux", 8'h01, input_sel)
      `CHK("rst_ofs", 16'h0000, offset_word)
      `CHK("rst_corr", 25'h0, corr_sample)
      for (int i = 0; i < 4; i++) begin
         rdchk(i);
      end
      chk_outs;
   endtask

   // Loads an offset, sends one sample and checks the saturated result.
   task smp(logic [15:0] ofs, logic [23:0] raw);
      int d;
      logic [23:0] ed;
      logic eo;
      wr(2, ofs[7:0]);
      wr(3, ofs[15:8]);
      chk_outs;
      d = $signed(raw) - $signed({ofs, 8'h00});
      ed = d[23:0];
      eo = 1'b0;
      if (d > 8388607) begin
         ed = 24'h7fffff;
         eo = 1'b1;
      end else if (d < -8388608) begin
         ed = 24'h800000;
         eo = 1'b1;
      end
      @(posedge pclk);
      raw_sample <= {1'b1, raw};
      @(posedge pclk);
      raw_sample <= '0;
      #1;
      `CHK("corr_valid", 1'b1, corr_sample.valid)
      `CHK("corr_data", ed, corr_sample.data)
      `CHK("corr_ovf", eo, corr_overflow)
      @(posedge pclk);
      #1;
      `CHK("corr_pulse", 1'b0, corr_sample.valid)
   endtask

   // Prints the counts and the verdict, then stops.
   task end_sim;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence: reset, field decodes, random traffic, samples.
   initial begin
      int i;
      logic [31:0] r;
      logic [31:0] q;
      logic [ADDR_W-1:0] a;
      errors = 0;
      checked = 0;
      seed = 32'he6c70e72;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      raw_sample = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rst_chk;
      for (i = 0; i < 8; i++) begin
         wr(0, {i[1:0], i[2:0], 3'(7 - i)});
         chk_outs;
      end
      for (i = 0; i < 16; i++) begin
         wr(1, {i[3:0], 4'(15 - i)});
         chk_outs;
         rdchk(1);
      end
      repeat (48) begin
         r = rnd();
         i = int'(r[1:0]);
         a = r[16] ? adr(4 + int'(r[8:4])) : (adr(i) | 12'(r[15:14] | 2'b01));
         case (r[3:2])
            2'b00: wr(i, r[31:24]);
            2'b01: rdchk(i);
            2'b10: begin
               apb(1'b1, adr(i), r[31:24], 4'he);
               `CHK("strb_err", 1'b0, err)
            end
            default: begin
               apb(r[17], a, r[31:24], 4'hf);
               `CHK("bad_err", 1'b1, err)
               `CHK("bad_rd", 32'h0, r[17] ? 32'h0 : rd)
            end
         endcase
         #1;
         chk_outs;
         rdchk(i);
      end
      smp(16'h8000, 24'h7fffff);
      smp(16'h7fff, 24'h800000);
      repeat (12) begin
         r = rnd();
         q = rnd();
         smp(r[15:0], q[23:0]);
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rst_chk;
      end_sim;
   end

   // Watchdog: the tests need well under 3000 cycles.
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      end_sim;
   end

endmodule
